// file: logic/acs_pkg.sv
// Package for the converter sequencer: register offsets, field positions, modes, timing.
// Assumes a plain strobe register port with 8-bit data.
package acs_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned RES_W  = 12;
  // Register offsets
  localparam logic [3:0] OFF_CTRL_MAIN   = 4'h0;
  localparam logic [3:0] OFF_COMPUTE     = 4'h1;
  localparam logic [3:0] OFF_RES_HI      = 4'h2;
  localparam logic [3:0] OFF_RES_LO      = 4'h3;
  localparam logic [3:0] OFF_PREV_HI     = 4'h4;
  localparam logic [3:0] OFF_PREV_LO     = 4'h5;
  localparam logic [3:0] OFF_SETPOINT_HI = 4'h6;
  localparam logic [3:0] OFF_SETPOINT_LO = 4'h7;
  localparam logic [3:0] OFF_LOWER_HI    = 4'h8;
  localparam logic [3:0] OFF_LOWER_LO    = 4'h9;
  localparam logic [3:0] OFF_UPPER_HI    = 4'ha;
  localparam logic [3:0] OFF_UPPER_LO    = 4'hb;
  localparam logic [3:0] OFF_SEQ_CFG     = 4'hc;
  localparam logic [3:0] OFF_IRQ_STATUS  = 4'hd;
  localparam logic [3:0] OFF_IRQ_MASK    = 4'he;
  localparam logic [3:0] OFF_ERR_HI      = 4'hf;
  // Main control fields
  localparam int unsigned B_ENABLE   = 7;
  localparam int unsigned B_CONTINUOUS_RETRIGGER     = 6;
  localparam int unsigned B_CLKSEL   = 4;
  localparam int unsigned B_JUSTIFY  = 2;
  localparam int unsigned B_GO       = 0;
  localparam logic [7:0]  CTRL_MASK  = 8'hd5;
  // Compute control fields
  localparam int unsigned B_ERROR_MODE_A_LO  = 4;
  localparam int unsigned B_STOP     = 3;
  localparam int unsigned B_TMD_LO   = 0;
  localparam logic [7:0]  COMP_MASK  = 8'h7f;
  // Sequence config: double sample, previous select, clock divider
  localparam int unsigned B_DOUBLE_SAMPLE_ENABLE     = 7;
  localparam int unsigned B_PSIS     = 6;
  localparam int unsigned B_DIV_LO   = 0;
  localparam int unsigned DIV_W      = 6;
  // Status bits
  localparam int unsigned IRQ_DONE   = 0;
  localparam int unsigned IRQ_THR    = 1;
  // Error modes
  localparam logic [2:0] ERROR_MODE_A_RES_PREV  = 3'h0;
  localparam logic [2:0] ERROR_MODE_A_RES_SETP  = 3'h1;
  localparam logic [2:0] ERROR_MODE_A_RES_FILT  = 3'h2;
  localparam logic [2:0] ERROR_MODE_A_PREV_FILT = 3'h4;
  localparam logic [2:0] ERROR_MODE_A_FILT_SETP = 3'h5;
  // Threshold modes
  localparam logic [2:0] TMD_NEVER   = 3'h0;
  localparam logic [2:0] TMD_BELOW   = 3'h1;
  localparam logic [2:0] TMD_ATABOVE = 3'h2;
  localparam logic [2:0] TMD_INSIDE  = 3'h3;
  localparam logic [2:0] TMD_OUTSIDE = 3'h4;
  localparam logic [2:0] TMD_LEUPPER = 3'h5;
  localparam logic [2:0] TMD_GTUPPER = 3'h6;
  localparam logic [2:0] TMD_ALWAYS  = 3'h7;
  // Phase end counts in conversion-clock ticks; each phase lasts this count plus one tick
  localparam logic [7:0] PRECHARGE_TICKS = 8'h08;
  localparam logic [7:0] ACQUIRE_TICKS   = 8'h08;
  // Filter weight as a right shift
  localparam int unsigned FILT_SHIFT = 2;
endpackage

// file: logic/acs_clk_tick.sv
// Conversion tick generator: system clock divider or the dedicated RC oscillator.
// Assumes the RC oscillator input is already synchronous to i_clk.
`timescale 1ns/1ps
module acs_clk_tick #(
  parameter int unsigned DIV_W = 6
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_use_rc,
  input  wire logic [DIV_W-1:0] i_div,
  input  wire logic             i_rc_osc,
  output logic                  o_tick
);
  logic [DIV_W-1:0] count;
  logic             rc_prev;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      count   <= '0;
      rc_prev <= 1'b0;
      o_tick  <= 1'b0;
    end else begin
      rc_prev <= i_rc_osc;
      if (i_use_rc) begin // [RULE_18]
        count  <= '0;
        o_tick <= i_rc_osc & ~rc_prev;
      end else if (count >= i_div) begin // [RULE_18]
        count  <= '0;
        o_tick <= 1'b1;
      end else begin
        count  <= count + 1'b1;
        o_tick <= 1'b0;
      end
    end
  end
endmodule

// file: logic/acs_sequencer.sv
// Converter sequencer: registers, precharge/acquire/convert phases, computation, interrupts.
// Assumes a comparator answer from the converter core on every conversion tick.
// Operation
// [RULE_01] Twelve-bit successive approximation result into result pair
// [RULE_02] Keep current and previous result sets
// [RULE_03] Completion and threshold interrupts, both wake sleep
// [RULE_04] Precharge: disconnect hold, drive opposite rails
// [RULE_05] End precharge: rails off, reconnect, acquire, convert
// [RULE_06] Repeat sequence with inverted precharge levels
// [RULE_07] Double sample runs both without software
// [RULE_08] Writing go starts; hardware clears on completion
// [RULE_09] Enable must be set before go; the code also starts on a go written in the same write that sets enable
// [RULE_10] Continuous mode retriggers until stop condition
// [RULE_11] Software abort copies partial, no flags
// [RULE_12] Three-bit error mode depends on sample mode
// [RULE_13] Error mode encodings, reserved codes give zero
// [RULE_14] Threshold mode encodings select interrupt test
// [RULE_15] Stop-on-threshold ends continuous retriggering
// [RULE_16] Left justify puts bits high, zero nibble
// [RULE_17] Justify bit applies to current and previous
// [RULE_18] Clock source: RC oscillator or divided clock
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
module acs_sequencer #(
  parameter int unsigned RES_W = acs_pkg::RES_W,
  parameter int unsigned DIV_W = acs_pkg::DIV_W
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  input  wire logic [acs_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic [7:0]                      o_rdata,
  input  wire logic                       i_rc_osc,
  input  wire logic                       i_cmp_high,
  output logic [RES_W-1:0]                o_dac_code,
  output logic                            o_hold_connect,
  output logic                            o_hold_pre_high,
  output logic                            o_hold_pre_low,
  output logic                            o_sense_pre_high,
  output logic                            o_sense_pre_low,
  output logic                            o_sampling,
  output logic                            o_irq,
  output logic                            o_wake
);
  typedef enum logic [4:0] {
    ACS_IDLE   = 5'h01,
    ACS_PRECH  = 5'h02,
    ACS_ACQ    = 5'h04,
    ACS_CONV   = 5'h08,
    ACS_FINISH = 5'h10
  } acs_state_t;

  acs_state_t       state;
  logic [7:0]       ctrl;
  logic [7:0]       comp;
  logic [7:0]       cfg;
  logic [1:0]       irq_status;
  logic [1:0]       irq_mask;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] prev;
  logic [RES_W-1:0] first_sample;
  logic [RES_W-1:0] setpoint;
  logic [RES_W-1:0] lower;
  logic [RES_W-1:0] upper;
  logic [RES_W-1:0] filtered;
  logic [RES_W:0]   err;
  logic [RES_W-1:0] sar;
  logic [RES_W-1:0] trial;
  logic [3:0]       bit_idx;
  logic [7:0]       phase_cnt;
  logic             second;
  logic             invert;
  logic             tick;
  logic             go_set_sw;
  logic             go_clr_sw;
  logic             conv_done;
  logic             seq_done;
  logic             thr_hit;
  logic             last_bit;
  logic [RES_W:0]   next_err;
  logic [RES_W-1:0] final_code;
  logic             cmp_valid;

  // Signed difference, one bit wider than the operands
  function automatic logic [RES_W:0] acs_diff(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
    acs_diff = {1'b0, a} - {1'b0, b};
  endfunction

  // Signed less-than on the widened error
  function automatic logic acs_lt(input logic [RES_W:0] a, input logic [RES_W-1:0] b);
    acs_lt = $signed(a) < $signed({1'b0, b});
  endfunction

  function automatic logic [7:0] acs_hi(input logic [RES_W-1:0] v, input logic right);
    acs_hi = right ? {4'h0, v[11:8]} : v[11:4]; // [RULE_16] [RULE_17]
  endfunction

  function automatic logic [7:0] acs_lo(input logic [RES_W-1:0] v, input logic right);
    acs_lo = right ? v[7:0] : {v[3:0], 4'h0}; // [RULE_16] [RULE_17]
  endfunction

  acs_clk_tick #(.DIV_W(DIV_W)) u_tick (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_use_rc (ctrl[acs_pkg::B_CLKSEL]),
    .i_div    (cfg[acs_pkg::B_DIV_LO +: DIV_W]),
    .i_rc_osc (i_rc_osc),
    .o_tick   (tick)
  );

  assign go_set_sw = i_wr && i_addr == acs_pkg::OFF_CTRL_MAIN && i_wdata[acs_pkg::B_GO]
                     && i_wdata[acs_pkg::B_ENABLE]; // [RULE_09]
  assign go_clr_sw = i_wr && i_addr == acs_pkg::OFF_CTRL_MAIN && !i_wdata[acs_pkg::B_GO]
                     && ctrl[acs_pkg::B_GO];
  assign trial     = sar | (12'h800 >> bit_idx);
  assign last_bit  = bit_idx == 4'hb;
  // Decide only once the comparator sees the trial code
  assign cmp_valid = tick && o_dac_code == trial;
  assign conv_done = state == ACS_CONV && cmp_valid && last_bit;
  assign final_code = i_cmp_high ? trial : sar;
  // Double sample completes only after the inverted second pass
  assign seq_done  = state == ACS_FINISH;

  // Error computation; result term becomes the sample difference in double mode
  always_comb begin
    next_err  = '0;
    unique case (comp[acs_pkg::B_ERROR_MODE_A_LO +: 3]) // [RULE_12] [RULE_13]
      acs_pkg::ERROR_MODE_A_RES_PREV:  next_err = acs_diff(result, prev);
      acs_pkg::ERROR_MODE_A_RES_SETP:  next_err = cfg[acs_pkg::B_DOUBLE_SAMPLE_ENABLE] ? acs_diff(result, prev) - {1'b0, setpoint}
                                                                : acs_diff(result, setpoint);
      acs_pkg::ERROR_MODE_A_RES_FILT:  next_err = cfg[acs_pkg::B_DOUBLE_SAMPLE_ENABLE] ? acs_diff(result, prev) - {1'b0, filtered}
                                                                : acs_diff(result, filtered);
      acs_pkg::ERROR_MODE_A_PREV_FILT: next_err = acs_diff(prev, filtered);
      acs_pkg::ERROR_MODE_A_FILT_SETP: next_err = acs_diff(filtered, setpoint);
      default:                 next_err = '0;
    endcase
  end

  always_comb begin
    unique case (comp[acs_pkg::B_TMD_LO +: 3]) // [RULE_14]
      acs_pkg::TMD_NEVER:   thr_hit = 1'b0;
      acs_pkg::TMD_BELOW:   thr_hit = acs_lt(next_err, lower);
      acs_pkg::TMD_ATABOVE: thr_hit = !acs_lt(next_err, lower);
      acs_pkg::TMD_INSIDE:  thr_hit = !acs_lt(next_err, lower) && next_err != {1'b0, lower}
                                      && acs_lt(next_err, upper);
      acs_pkg::TMD_OUTSIDE: thr_hit = acs_lt(next_err, lower) || !(acs_lt(next_err, upper)
                                      || next_err == {1'b0, upper});
      acs_pkg::TMD_LEUPPER: thr_hit = acs_lt(next_err, upper) || next_err == {1'b0, upper};
      acs_pkg::TMD_GTUPPER: thr_hit = !(acs_lt(next_err, upper) || next_err == {1'b0, upper});
      acs_pkg::TMD_ALWAYS:  thr_hit = 1'b1;
    endcase
  end

  // Phase sequencing
  always_ff @(posedge i_clk) begin
    if (i_srst || go_clr_sw || !ctrl[acs_pkg::B_ENABLE]) begin
      state     <= ACS_IDLE; // [RULE_11]
      phase_cnt <= '0;
      bit_idx   <= '0;
      sar       <= '0;
      second    <= 1'b0;
      invert    <= 1'b0;
    end else begin
      unique case (state)
        ACS_IDLE: begin
          if (ctrl[acs_pkg::B_GO]) begin
            state     <= ACS_PRECH;
            phase_cnt <= '0;
            second    <= 1'b0;
            invert    <= 1'b0;
          end
        end
        ACS_PRECH: begin
          if (tick) begin
            if (phase_cnt == acs_pkg::PRECHARGE_TICKS) begin
              state     <= ACS_ACQ; // [RULE_05]
              phase_cnt <= '0;
            end else begin
              phase_cnt <= phase_cnt + 8'h01;
            end
          end
        end
        ACS_ACQ: begin
          if (tick) begin
            if (phase_cnt == acs_pkg::ACQUIRE_TICKS) begin
              state   <= ACS_CONV; // [RULE_05]
              bit_idx <= '0;
              sar     <= '0;
            end else begin
              phase_cnt <= phase_cnt + 8'h01;
            end
          end
        end
        ACS_CONV: begin
          if (cmp_valid) begin
            sar <= final_code; // [RULE_01]
            if (last_bit) begin
              if (cfg[acs_pkg::B_DOUBLE_SAMPLE_ENABLE] && !second) begin
                state     <= ACS_PRECH; // [RULE_06] [RULE_07]
                second    <= 1'b1;
                invert    <= 1'b1;
                phase_cnt <= '0;
              end else begin
                state <= ACS_FINISH;
              end
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        ACS_FINISH: begin
          state <= ACS_IDLE;
        end
      endcase
    end
  end

  // Result capture; prev shifts on each single-sample completion and takes the first sample in double mode, abort copies the partial value
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      result       <= '0;
      prev         <= '0;
      first_sample <= '0;
    end else if (go_clr_sw && state != ACS_IDLE) begin
      result <= sar; // [RULE_11]
    end else if (conv_done) begin
      if (cfg[acs_pkg::B_DOUBLE_SAMPLE_ENABLE] && !second) begin
        first_sample <= final_code;
      end else if (cfg[acs_pkg::B_DOUBLE_SAMPLE_ENABLE]) begin
        prev   <= first_sample; // [RULE_02]
        result <= final_code;
      end else begin
        prev   <= result; // [RULE_02]
        result <= final_code; // [RULE_01]
      end
    end
  end

  // First-order low-pass filter and error are updated only on a full completion
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      filtered <= '0;
      err      <= '0;
    end else if (seq_done) begin
      filtered <= filtered - (filtered >> acs_pkg::FILT_SHIFT) + (result >> acs_pkg::FILT_SHIFT);
      err      <= next_err;
    end
  end

  // Control registers; go is cleared by hardware, a start request beats the clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl <= '0;
    end else if (i_wr && i_addr == acs_pkg::OFF_CTRL_MAIN) begin
      ctrl <= (i_wdata & acs_pkg::CTRL_MASK & 8'hfe) | {7'h00, go_set_sw | (ctrl[acs_pkg::B_GO]
              & i_wdata[acs_pkg::B_GO] & i_wdata[acs_pkg::B_ENABLE])}; // [RULE_08] [RULE_09]
    end else begin
      if (!ctrl[acs_pkg::B_ENABLE]) begin
        ctrl[acs_pkg::B_GO] <= 1'b0;
      end else if (seq_done) begin
        if (!ctrl[acs_pkg::B_CONTINUOUS_RETRIGGER]) begin
          ctrl[acs_pkg::B_GO] <= 1'b0; // [RULE_08] [RULE_10]
        end else if (comp[acs_pkg::B_STOP] && thr_hit) begin
          ctrl[acs_pkg::B_GO] <= 1'b0; // [RULE_15]
        end else begin
          ctrl[acs_pkg::B_GO] <= 1'b1; // [RULE_10] [RULE_15]
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      comp     <= '0;
      cfg      <= '0;
      setpoint <= '0;
      lower    <= '0;
      upper    <= '0;
      irq_mask <= '0;
    end else if (i_wr) begin
      unique case (i_addr)
        acs_pkg::OFF_COMPUTE:     comp           <= i_wdata & acs_pkg::COMP_MASK;
        acs_pkg::OFF_SEQ_CFG:     cfg            <= i_wdata;
        acs_pkg::OFF_SETPOINT_HI: setpoint[11:8] <= i_wdata[3:0];
        acs_pkg::OFF_SETPOINT_LO: setpoint[7:0]  <= i_wdata;
        acs_pkg::OFF_LOWER_HI:    lower[11:8]    <= i_wdata[3:0];
        acs_pkg::OFF_LOWER_LO:    lower[7:0]     <= i_wdata;
        acs_pkg::OFF_UPPER_HI:    upper[11:8]    <= i_wdata[3:0];
        acs_pkg::OFF_UPPER_LO:    upper[7:0]     <= i_wdata;
        acs_pkg::OFF_IRQ_MASK:    irq_mask       <= i_wdata[1:0];
        default:                  ;
      endcase
    end
  end

  // Sticky status, cleared by a read; a new event in the read cycle survives
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_status <= '0;
    end else begin
      irq_status <= ((i_rd && i_addr == acs_pkg::OFF_IRQ_STATUS) ? 2'h0 : irq_status)
                    | {seq_done && thr_hit, seq_done}; // [RULE_03]
    end
  end

  assign o_irq  = |(irq_status & irq_mask); // [RULE_03]
  assign o_wake = o_irq; // [RULE_03]

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        acs_pkg::OFF_CTRL_MAIN:  o_rdata <= ctrl;
        acs_pkg::OFF_COMPUTE:    o_rdata <= comp;
        acs_pkg::OFF_RES_HI:     o_rdata <= acs_hi(result, ctrl[acs_pkg::B_JUSTIFY]);
        acs_pkg::OFF_RES_LO:     o_rdata <= acs_lo(result, ctrl[acs_pkg::B_JUSTIFY]);
        acs_pkg::OFF_PREV_HI:    o_rdata <= acs_hi(prev, ctrl[acs_pkg::B_JUSTIFY]);
        acs_pkg::OFF_PREV_LO:    o_rdata <= acs_lo(prev, ctrl[acs_pkg::B_JUSTIFY]);
        acs_pkg::OFF_SEQ_CFG:    o_rdata <= cfg;
        acs_pkg::OFF_IRQ_STATUS: o_rdata <= {6'h00, irq_status};
        acs_pkg::OFF_IRQ_MASK:   o_rdata <= {6'h00, irq_mask};
        acs_pkg::OFF_ERR_HI:     o_rdata <= err[RES_W:5];
        default:                 o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Analog controls; precharge rails swap on the inverted pass
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_hold_connect   <= 1'b0;
      o_hold_pre_high  <= 1'b0;
      o_hold_pre_low   <= 1'b0;
      o_sense_pre_high <= 1'b0;
      o_sense_pre_low  <= 1'b0;
      o_sampling       <= 1'b0;
      o_dac_code       <= '0;
    end else begin
      o_hold_connect   <= state == ACS_ACQ; // [RULE_04] [RULE_05]
      o_hold_pre_high  <= state == ACS_PRECH && !invert; // [RULE_04] [RULE_06]
      o_hold_pre_low   <= state == ACS_PRECH && invert;
      o_sense_pre_high <= state == ACS_PRECH && invert;
      o_sense_pre_low  <= state == ACS_PRECH && !invert;
      o_sampling       <= state != ACS_IDLE;
      o_dac_code       <= trial;
    end
  end
endmodule

// file: verification/acs_sequencer_properties.sv
// Checker: rail, phase, start and abort relations at the sequencer ports.
// Assumes binding to acs_sequencer; all sampled on rising i_clk.
`timescale 1ns/1ps
module acs_sequencer_properties #(
  parameter int unsigned RES_W = acs_pkg::RES_W
) (
  input wire logic                       i_clk,
  input wire logic                       i_srst,
  input wire logic [acs_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0]                 i_wdata,
  input wire logic                       i_wr,
  input wire logic [RES_W-1:0]           o_dac_code,
  input wire logic                       o_hold_connect,
  input wire logic                       o_hold_pre_high,
  input wire logic                       o_hold_pre_low,
  input wire logic                       o_sense_pre_high,
  input wire logic                       o_sense_pre_low,
  input wire logic                       o_sampling,
  input wire logic                       o_irq,
  input wire logic                       o_wake
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic ctrl_wr;
  assign ctrl_wr = i_wr && (i_addr == acs_pkg::OFF_CTRL_MAIN);

  a_wake_follows_irq: assert property (o_wake == o_irq)
    else $error("wake differs from irq");
  a_rails_apart: assert property (!(o_hold_pre_high && o_hold_pre_low) && !(o_sense_pre_high && o_sense_pre_low))
    else $error("rails both on");
  a_first_pass_rails: assert property (o_hold_pre_high |-> o_sense_pre_low && !o_hold_connect)
    else $error("first pass rails wrong");
  a_second_pass_rails: assert property (o_hold_pre_low |-> o_sense_pre_high && !o_hold_connect)
    else $error("second pass rails wrong");
  a_connect_rails_off: assert property (o_hold_connect |-> !(o_hold_pre_high || o_hold_pre_low || o_sense_pre_high || o_sense_pre_low))
    else $error("rails on while connected");
  a_prech_then_acquire: assert property ($fell(o_hold_pre_high || o_hold_pre_low) && o_sampling |-> o_hold_connect)
    else $error("no acquire after precharge");
  // An abort may cut precharge short, so a drop of sampling ends the run early
  a_prech_min_len: assert property ($rose(o_hold_pre_high) |-> (o_hold_pre_high || !o_sampling)[*8])
    else $error("precharge too short");
  a_sar_msb_first: assert property ($fell(o_hold_connect) && o_sampling |-> ##[0:8] (o_dac_code == {1'b1, {(RES_W-1){1'b0}}}))
    else $error("first trial not top bit");
  a_go_starts: assert property (ctrl_wr && i_wdata[7] && i_wdata[0] && !o_sampling |-> ##[1:3] o_sampling)
    else $error("go did not start");
  a_go_needs_enable: assert property (ctrl_wr && !i_wdata[7] && !o_sampling |=> !o_sampling[*4])
    else $error("go without enable started");
  a_abort_stops: assert property (ctrl_wr && i_wdata[7] && !i_wdata[0] && o_sampling |-> ##[1:3] !o_sampling)
    else $error("abort did not stop");
endmodule

bind acs_sequencer acs_sequencer_properties #(.RES_W(RES_W)) u_props (
  .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .o_dac_code(o_dac_code),
  .o_hold_connect(o_hold_connect), .o_hold_pre_high(o_hold_pre_high), .o_hold_pre_low(o_hold_pre_low),
  .o_sense_pre_high(o_sense_pre_high), .o_sense_pre_low(o_sense_pre_low), .o_sampling(o_sampling),
  .o_irq(o_irq), .o_wake(o_wake)
);

// file: verification/acs_analog_model.sv
// Behavioural hold node, sensor and comparator facing the sequencer.
// Assumes an ideal comparator: a conversion lands on the level.
`timescale 1ns/1ps
module acs_analog_model (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_dac_code,
  input  wire logic        i_hold_pre_high,
  input  wire logic        i_hold_pre_low,
  input  wire logic [11:0] i_level_a,
  input  wire logic [11:0] i_level_b,
  output logic             o_cmp_high
);
  logic inverted;
  initial inverted = 1'b0;
  // The divided voltage depends on which rail the hold node saw last
  always @(posedge i_clk) begin
    if (i_hold_pre_high) inverted <= 1'b0;
    else if (i_hold_pre_low) inverted <= 1'b1;
  end
  assign o_cmp_high = ((inverted ? i_level_b : i_level_a) >= i_dac_code);
endmodule

// file: verification/acs_sequencer_test.sv
// Self-checking bench for the converter sequencer with the analog model on its far side.
// Assumes the acs_pkg map and phases; divider 0 ticks every clock.
`timescale 1ns/1ps
module acs_sequencer_test;
  logic        i_clk, i_srst, i_wr, i_rd, i_rc_osc, cmp_high;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata;
  logic [11:0] dac_code, level_a, level_b;
  logic        hold_con, h_hi, h_lo, s_hi, s_lo, o_sampling, o_irq, o_wake;
  int          mismatches, n_checks, cyc;
  localparam logic [3:0] CT = acs_pkg::OFF_CTRL_MAIN, CP = acs_pkg::OFF_COMPUTE, ST = acs_pkg::OFF_IRQ_STATUS;
  localparam logic [3:0] RH = acs_pkg::OFF_RES_HI, RL = acs_pkg::OFF_RES_LO, CF = acs_pkg::OFF_SEQ_CFG;
  localparam logic [3:0] MK = acs_pkg::OFF_IRQ_MASK, ER = acs_pkg::OFF_ERR_HI;

  acs_sequencer DUT (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_rc_osc(i_rc_osc), .i_cmp_high(cmp_high), .o_dac_code(dac_code),
    .o_hold_connect(hold_con), .o_hold_pre_high(h_hi), .o_hold_pre_low(h_lo), .o_sense_pre_high(s_hi),
    .o_sense_pre_low(s_lo), .o_sampling(o_sampling), .o_irq(o_irq), .o_wake(o_wake));
  acs_analog_model u_analog (
    .i_clk(i_clk), .i_dac_code(dac_code), .i_hold_pre_high(h_hi), .i_hold_pre_low(h_lo),
    .i_level_a(level_a), .i_level_b(level_b), .o_cmp_high(cmp_high));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // RC source slower than the divider path
  initial begin
    i_rc_osc = 1'b0;
    forever begin
      repeat (3) @(posedge i_clk);
      i_rc_osc <= ~i_rc_osc;
    end
  end

  task automatic close_out;
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {4'h0, exp}, {4'h0, d});
  endtask
  task automatic wait_samp(input logic v, input int lim, output int n);
    n = 0;
    while (o_sampling !== v && n < lim) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n >= lim) chk("o_sampling", {11'h0, v}, {11'h0, o_sampling});
  endtask
  task automatic conv(input logic [7:0] ctrl, input int lim, output int c);
    int n;
    wr(CT, ctrl);
    wait_samp(1'b1, 4, n);
    wait_samp(1'b0, lim, c);
  endtask

  task automatic t_regs;
    rd_chk("ctrl", CT, 8'h00);
    rd_chk("status", ST, 8'h00);
    wr(CT, 8'h7e);
    rd_chk("ctrl", CT, 8'h54);
    wr(CP, 8'hff);
    rd_chk("compute", CP, 8'h7f);
    wr(CP, 8'h00);
    for (int a = 2; a < 6; a++) begin
      wr(4'(a), 8'hff);
      rd_chk("result", 4'(a), 8'h00);
    end
    wr(CT, 8'h01);
    repeat (4) @(posedge i_clk);
    #1;
    chk("o_sampling", 12'h0, {11'h0, o_sampling});
    rd_chk("ctrl", CT, 8'h00);
  endtask

  task automatic t_single;
    int n;
    level_a = 12'h5a3;
    wr(MK, 8'h01);
    wr(CT, 8'h81);
    wait_samp(1'b1, 4, n);
    rd_chk("ctrl", CT, 8'h81);
    wait_samp(1'b0, 200, n);
    rd_chk("ctrl", CT, 8'h80);
    chk("o_irq", 12'h1, {11'h0, o_irq});
    rd_chk("res_hi", RH, 8'h5a);
    rd_chk("res_lo", RL, 8'h30);
    rd_chk("status", ST, 8'h01);
    chk("o_irq", 12'h0, {11'h0, o_irq});
    wr(MK, 8'h00);
    level_a = 12'h2c7;
    conv(8'h85, 200, n);
    chk("o_irq", 12'h0, {11'h0, o_irq});
    wr(MK, 8'h01);
    repeat (2) @(posedge i_clk);
    #1;
    chk("o_irq", 12'h1, {11'h0, o_irq});
    rd_chk("res_hi", RH, 8'h02);
    rd_chk("res_lo", RL, 8'hc7);
    rd_chk("prev_hi", acs_pkg::OFF_PREV_HI, 8'h05);
    rd_chk("prev_lo", acs_pkg::OFF_PREV_LO, 8'ha3);
    rd_chk("status", ST, 8'h01);
  endtask

  task automatic t_double;
    int n;
    level_a = 12'h300;
    level_b = 12'h120;
    wr(CF, 8'h80);
    conv(8'h85, 300, n);
    rd_chk("prev_hi", acs_pkg::OFF_PREV_HI, 8'h03);
    rd_chk("res_hi", RH, 8'h01);
    rd_chk("res_lo", RL, 8'h20);
    rd_chk("status", ST, 8'h01);
  endtask

  // Error 128 lies between lower 64 and upper 192
  task automatic t_thresh;
    int n;
    logic [7:0] hit;
    logic [2:0] cs [5];
    hit = 8'hac;
    cs = '{3'h0, 3'h3, 3'h2, 3'h4, 3'h5};
    level_a = 12'h180;
    wr(CF, 8'h00);
    wr(acs_pkg::OFF_SETPOINT_HI, 8'h01);
    wr(acs_pkg::OFF_SETPOINT_LO, 8'h00);
    wr(acs_pkg::OFF_LOWER_LO, 8'h40);
    wr(acs_pkg::OFF_UPPER_LO, 8'hc0);
    for (int t = 0; t < 8; t++) begin
      wr(CP, {5'b00010, 3'(t)});
      conv(8'h85, 200, n);
      rd_chk("err", ER, 8'h04);
      rd_chk("status", ST, {6'h0, hit[t], 1'b1});
    end
    for (int i = 0; i < 5; i++) begin
      wr(CP, {1'b0, cs[i], 4'h7});
      conv(8'h85, 200, n);
      if (i < 2) rd_chk("err", ER, 8'h00);
      rd_chk("status", ST, 8'h03);
    end
  endtask

  task automatic t_continuous_retrigger;
    int n;
    wr(CP, 8'h10);
    wr(CT, 8'hc1);
    wait_samp(1'b1, 4, n);
    repeat (120) @(posedge i_clk);
    #1;
    chk("o_sampling", 12'h1, {11'h0, o_sampling});
    rd_chk("status", ST, 8'h01);
    wr(CT, 8'hc0);
    wait_samp(1'b0, 6, n);
    wr(CP, 8'h1a);
    conv(8'hc1, 200, n);
    rd_chk("status", ST, 8'h03);
    rd_chk("ctrl", CT, 8'hc0);
  endtask

  task automatic t_abort;
    int n;
    logic [7:0] d;
    level_a = 12'hfff;
    wr(CP, 8'h07);
    wr(CT, 8'h81);
    wait_samp(1'b1, 4, n);
    repeat (24) @(posedge i_clk);
    wr(CT, 8'h80);
    wait_samp(1'b0, 6, n);
    rd_chk("status", ST, 8'h00);
    rd(RH, d);
    chk("partial_hi", 12'h00f, {8'h0, d[7:4]});
    rd_chk("res_lo", RL, 8'h00);
  endtask

  // Divider 3: tick per 4 clocks; RC: per 6
  task automatic t_clock;
    level_a = 12'h180;
    wr(CF, 8'h03);
    conv(8'h81, 400, cyc);
    chk("div_slow", 12'h1, {11'h0, cyc >= 116});
    rd_chk("res_hi", RH, 8'h18);
    wr(CF, 8'h00);
    conv(8'h91, 400, cyc);
    chk("rc_slow", 12'h1, {11'h0, cyc >= 174});
    rd_chk("res_hi", RH, 8'h18);
  endtask

  initial begin
    mismatches = 0;
    n_checks = 0;
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    level_a = 12'h000;
    level_b = 12'h000;
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    t_regs();
    t_single();
    t_double();
    t_thresh();
    t_continuous_retrigger();
    t_abort();
    t_clock();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    close_out();
  end
endmodule
